// [aofc_cap_model.sv]
`timescale 1ns/100ps
module aofc_cap_model import aofc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic data_clk_i,
   input wire aofc_sample_t word_i,
   output aofc_sample_t cap_word_o,
   output int cap_cnt_o
);
   logic clk_q;
   // capture on the falling edge of the data clock: the word lands a
   // cycle before the rise, so mid-period it has long settled
   always_ff @(posedge sys_clk_i) begin
      clk_q <= data_clk_i;
      if (!rstn_i) begin
         cap_cnt_o <= 0;
         cap_word_o <= '0;
      end else if (clk_q && !data_clk_i) begin
         cap_word_o <= word_i;
         cap_cnt_o <= cap_cnt_o + 1;
      end
   end
endmodule

// [aofc_pkg.sv]
package aofc_pkg;
   // serial word layout
   localparam int WORD_BITS = 16;
   localparam int HDR_BITS = 8;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [6:0] ADDR_DRIVE = 7'h03;
   localparam logic [6:0] ADDR_FMT = 7'h04;
   localparam int SW_RESET_BIT = 7;
   // output_drive_mode_ctrl fields
   localparam int DRV_CUR_LSB = 4;
   localparam int DRV_TERM_BIT = 3;
   localparam int DRV_HIZ_BIT = 2;
   localparam int DRV_SIG_LSB = 0;
   localparam logic [6:0] DRV_RESET = 7'h00;
   // sample_format_ctrl fields
   localparam int FMT_TP_LSB = 3;
   localparam int FMT_ABP_BIT = 2;
   localparam int FMT_SCR_BIT = 1;
   localparam int FMT_SIGNED_BIT = 0;
   localparam logic [5:0] FMT_RESET = 6'h00;
   // output signalling codes
   localparam logic [1:0] SIG_CMOS = 2'h0;
   localparam logic [1:0] SIG_DDR_LVDS = 2'h1;
   localparam logic [1:0] SIG_DDR_CMOS = 2'h2;
   // test pattern codes
   localparam logic [2:0] TP_OFF = 3'h0;
   localparam logic [2:0] TP_ZERO = 3'h1;
   localparam logic [2:0] TP_ONE = 3'h3;
   localparam logic [2:0] TP_CHECK = 3'h5;
   localparam logic [2:0] TP_ALT = 3'h7;
   localparam logic [16:0] CHK_A = 17'h1_5555;
   localparam logic [16:0] CHK_B = 17'h0_aaaa;
   localparam logic [15:0] ABP_MASK = 16'haaaa;
   // drive current in 10 uA steps, doubled with termination
   localparam logic [9:0] CUR_WIDTH_MAX = 10'h384;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [1:0] {
      AOFC_IDLE = 2'b00,
      AOFC_SHIFT = 2'b01
   } aofc_state_t;

   typedef struct packed {
      logic overflow_flag;
      logic [15:0] sample_bits;
   } aofc_sample_t;
endpackage

// [aofc_top.sv]
`timescale 1ns/100ps

module aofc_fifo #(
   parameter int W = 17,
   parameter int D = 8
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic full_q, full_d, push, pop;

   always_comb begin
      push = in_valid_i && !full_q;
      pop = out_ready_i && (cnt_q != '0);
      wr_d = push ? ((wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d = pop ? ((rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
      full_d = (cnt_d == CW'(D));
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   assign in_ready_o = !full_q;
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
endmodule

module aofc_top import aofc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic link_clk_i,
   input wire aofc_sample_t sample_i,
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   output aofc_sample_t out_word_o,
   output logic out_oe_o,
   output logic output_data_clock_o,
   output logic [9:0] drive_current_o,
   output logic term_en_o,
   output logic lvds_en_o,
   output logic ddr_en_o
);
   // pin synchronisers: bit 0 cs_n, 1 sck, 2 sdi, 3 link clock
   logic [3:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
   logic cs_fall, cs_rise, sck_rise, sck_fall, lrise, lfall;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
      cs_fall = lvl_q[0] && !lvl_d[0];
      cs_rise = !lvl_q[0] && lvl_d[0];
      sck_rise = !lvl_q[1] && lvl_d[1];
      sck_fall = lvl_q[1] && !lvl_d[1];
      lrise = !lvl_q[3] && lvl_d[3];
      lfall = lvl_q[3] && !lvl_d[3];
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         s1_q <= 4'h1;
         s2_q <= 4'h1;
         s3_q <= 4'h1;
         lvl_q <= 4'h1;
      end else begin
         s1_q <= {link_clk_i, sdi_i, sck_i, cs_n_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   // serial configuration port
   aofc_state_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [7:0] rdsh_q, rdsh_d;
   logic [6:0] drv_q, drv_d;
   logic [5:0] fmt_q, fmt_d;
   logic oe_q, oe_d, wr_ev, rd_ev, rdm_q, rdm_d;

   function automatic logic [7:0] rd_reg(input logic [6:0] a,
      input logic [6:0] drv, input logic [5:0] fmt);
      if (a == ADDR_DRIVE) begin
         return {1'b0, drv};
      end else if (a == ADDR_FMT) begin
         return {2'b00, fmt};
      end else begin
         return 8'h00;
      end
   endfunction

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      rdsh_d = rdsh_q;
      drv_d = drv_q;
      fmt_d = fmt_q;
      oe_d = oe_q;
      rdm_d = rdm_q;
      wr_ev = 1'b0;
      rd_ev = 1'b0;
      case (st_q)
         AOFC_IDLE: begin
            oe_d = 1'b0;
            rdm_d = 1'b0;
            if (cs_fall) begin
               st_d = AOFC_SHIFT;
               cnt_d = '0;
            end
         end
         AOFC_SHIFT: begin
            if (cs_rise) begin
               st_d = AOFC_IDLE;
               oe_d = 1'b0;
               // a short word writes nothing
               wr_ev = (cnt_q == 5'(WORD_BITS)) && !sh_q[15];
               rd_ev = sh_q[15] || (cnt_q != 5'(WORD_BITS));
               if (wr_ev && sh_q[14:8] == ADDR_RESET &&
                   sh_q[SW_RESET_BIT]) begin
                  drv_d = DRV_RESET;
                  fmt_d = FMT_RESET;
               end else if (wr_ev && sh_q[14:8] == ADDR_DRIVE) begin
                  drv_d = sh_q[6:0];
               end else if (wr_ev && sh_q[14:8] == ADDR_FMT) begin
                  fmt_d = sh_q[5:0];
               end
            end else if (sck_rise && cnt_q < 5'(WORD_BITS)) begin
               // edges past the sixteenth are ignored
               sh_d = {sh_q[14:0], lvl_q[2]};
               cnt_d = cnt_q + 5'd1;
               if (cnt_q == 5'(HDR_BITS - 1)) begin
                  rdsh_d = rd_reg({sh_q[5:0], lvl_q[2]}, drv_q, fmt_q);
                  // r/w moves on with every shift, so keep it aside
                  rdm_d = sh_q[6];
               end
            end else if (sck_fall && rdm_q &&
                         cnt_q >= 5'(HDR_BITS) && cnt_q < 5'(WORD_BITS)) begin
               // read-back: sdi is shifted but never stored
               oe_d = !rdsh_q[7];
               rdsh_d = {rdsh_q[6:0], 1'b0};
            end
         end
         default: st_d = AOFC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         st_q <= AOFC_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         rdsh_q <= '0;
         drv_q <= DRV_RESET;
         fmt_q <= FMT_RESET;
         oe_q <= 1'b0;
         rdm_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rdsh_q <= rdsh_d;
         drv_q <= drv_d;
         fmt_q <= fmt_d;
         oe_q <= oe_d;
         rdm_q <= rdm_d;
      end
   end

   // open drain: only ever pulls low
   assign sdo_o = 1'b0;
   assign sdo_oe_o = oe_q;

   // sample path
   aofc_sample_t f_data, raw_q, raw_d, word_q, word_d, out_q, out_d;
   logic f_valid, f_ready, ph_q, ph_d;
   logic [9:0] cur_q, cur_d, cur_base;
   logic term_q, term_d, lvds_q, lvds_d, ddr_q, ddr_d, hiz_q, hiz_d, clk_q;

   aofc_fifo #(.W(17), .D(FIFO_DEPTH)) u_fifo (
      .clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(f_ready),
      .in_data_i(sample_i),
      .out_valid_o(f_valid),
      .out_ready_i(lrise),
      .out_data_o(f_data)
   );

   function automatic logic [9:0] cur_code(input logic [2:0] c);
      case (c)
         3'h0: return 10'h15e;
         3'h1: return 10'h190;
         3'h2: return 10'h1c2;
         3'h4: return 10'h12c;
         3'h5: return 10'h0fa;
         3'h6: return 10'h0d2;
         3'h7: return 10'h0af;
         default: return 10'h000;
      endcase
   endfunction

   function automatic aofc_sample_t fmt_word(input aofc_sample_t s,
      input logic [5:0] f, input logic ph);
      aofc_sample_t w;
      w = s;
      if (f[FMT_SIGNED_BIT] && !f[FMT_ABP_BIT]) begin
         w.sample_bits[15] = !w.sample_bits[15];
      end
      if (f[FMT_ABP_BIT]) begin
         w.sample_bits = w.sample_bits ^ ABP_MASK;
      end
      if (f[FMT_SCR_BIT]) begin
         w.sample_bits[15:1] = w.sample_bits[15:1] ^ {15{w.sample_bits[0]}};
      end
      case (f[FMT_TP_LSB +: 3])
         TP_ZERO: w = '0;
         TP_ONE: w = '1;
         TP_CHECK: w = ph ? CHK_B : CHK_A;
         TP_ALT: w = ph ? '1 : '0;
         default: w = w;
      endcase
      return w;
   endfunction

   // ddr halves: odd bits on the rising edge, even on the falling one
   function automatic aofc_sample_t ddr_half(input aofc_sample_t s,
      input logic odd);
      aofc_sample_t w;
      w = '0;
      w.overflow_flag = s.overflow_flag;
      for (int i = 0; i < 8; i++) begin
         w.sample_bits[i] = s.sample_bits[2 * i + (odd ? 1 : 0)];
      end
      return w;
   endfunction

   always_comb begin
      // 10 uA steps; doubled 4.5 mA is 900, so ten bits never overflow
      cur_base = cur_code(drv_q[DRV_CUR_LSB +: 3]);
      cur_d = drv_q[DRV_TERM_BIT] ? {cur_base[8:0], 1'b0} : cur_base;
      term_d = drv_q[DRV_TERM_BIT];
      hiz_d = drv_q[DRV_HIZ_BIT];
      lvds_d = drv_q[DRV_SIG_LSB +: 2] == SIG_DDR_LVDS;
      ddr_d = lvds_d || drv_q[DRV_SIG_LSB +: 2] == SIG_DDR_CMOS;
      raw_d = raw_q;
      word_d = word_q;
      ph_d = ph_q;
      out_d = out_q;
      if (lrise) begin
         if (f_valid) begin
            raw_d = f_data;
         end
         word_d = fmt_word(f_valid ? f_data : raw_q, fmt_q, ph_q);
         ph_d = !ph_q;
         out_d = ddr_q ? ddr_half(word_d, 1'b1) : word_d;
      end else if (lfall && ddr_q) begin
         out_d = ddr_half(word_q, 1'b0);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         cur_q <= '0;
         term_q <= 1'b0;
         hiz_q <= 1'b0;
         lvds_q <= 1'b0;
         ddr_q <= 1'b0;
         raw_q <= '0;
         word_q <= '0;
         ph_q <= 1'b0;
         out_q <= '0;
         clk_q <= 1'b0;
      end else begin
         cur_q <= cur_d;
         term_q <= term_d;
         hiz_q <= hiz_d;
         lvds_q <= lvds_d;
         ddr_q <= ddr_d;
         raw_q <= raw_d;
         word_q <= word_d;
         ph_q <= ph_d;
         out_q <= out_d;
         clk_q <= lvl_q[3];
      end
   end

   assign sample_ready_o = f_ready;
   assign out_word_o = out_q;
   assign out_oe_o = !hiz_q;
   assign output_data_clock_o = clk_q;
   assign drive_current_o = cur_q;
   assign term_en_o = term_q;
   assign lvds_en_o = lvds_q;
   assign ddr_en_o = ddr_q;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_cur;
      drv_q[6:4] == 3'h0 && !drv_q[3] |=> drive_current_o == 10'd350;
   endproperty
   a_cur: assert property (p_cur) else $error("bad drive current");
   property p_term;
      drv_q[6:4] == 3'h7 && drv_q[3] |=> drive_current_o == 10'd350
         && term_en_o;
   endproperty
   a_term: assert property (p_term) else $error("no doubling");
   property p_hiz;
      drv_q[2] |=> !out_oe_o;
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs not off");
   property p_mode;
      drv_q[1:0] == 2'h1 |=> lvds_en_o && ddr_en_o;
   endproperty
   a_mode: assert property (p_mode) else $error("bad mode");
   property p_zero;
      lrise && fmt_q[5:3] == TP_ZERO |=> out_word_o == '0;
   endproperty
   a_zero: assert property (p_zero) else $error("not all low");
   property p_chk;
      lrise && fmt_q[5:3] == TP_CHECK && !ddr_q &&
         (out_q == CHK_A || out_q == CHK_B) |=>
         (out_word_o == CHK_A || out_word_o == CHK_B) &&
         out_word_o != $past(out_word_o);
   endproperty
   a_chk: assert property (p_chk) else $error("checkerboard");
   property p_alt;
      lrise && fmt_q[5:3] == TP_ALT && !ddr_q |=>
         out_word_o == '0 || out_word_o == '1;
   endproperty
   a_alt: assert property (p_alt) else $error("alternating");
   property p_swrst;
      wr_ev && sh_q[14:8] == ADDR_RESET && sh_q[7] |=>
         drv_q == '0 && fmt_q == '0;
   endproperty
   a_swrst: assert property (p_swrst) else $error("soft reset");
   property p_rd;
      rd_ev |=> $stable(drv_q) && $stable(fmt_q);
   endproperty
   a_rd: assert property (p_rd) else $error("read changed reg");
   c_wr: cover property (wr_ev && sh_q[14:8] == ADDR_FMT);
   c_rd: cover property (sdo_oe_o);
   c_full: cover property (!sample_ready_o);
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top import aofc_pkg::*; ;
   logic sys_clk = 0, rstn = 0, cs_n = 1, sck = 0, sdi = 0;
   logic link_clk = 0, link_run = 0, valid = 0;
   aofc_sample_t smp = '0, out_word, cap, w1, w2;
   logic sdo, sdo_oe, ready, oe, dclk, term, lvds, ddr;
   logic [9:0] cur;
   logic [7:0] d, v;
   int cap_cnt, n, err_count = 0, n_checks = 0;
   logic [9:0] cur_tab [8] = '{10'h15e, 10'h190, 10'h1c2, 10'h000,
      10'h12c, 10'h0fa, 10'h0d2, 10'h0af};
   logic [7:0] pf [6] = '{8'h00, 8'h01, 8'h05, 8'h02, 8'h08, 8'h18};
   logic [16:0] pe [6] = '{17'h0_1235, 17'h0_9235, 17'h0_b89f,
      17'h0_edcb, 17'h0_0000, 17'h1_ffff};

   always #5 sys_clk = ~sys_clk;
   // link clock phase is deliberately unrelated to the system clock
   initial begin
      #3;
      forever begin
         #80;
         if (link_run) link_clk = ~link_clk;
      end
   end

   aofc_top u_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .cs_n_i(cs_n),
      .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
      .link_clk_i(link_clk), .sample_i(smp), .sample_valid_i(valid),
      .sample_ready_o(ready), .out_word_o(out_word), .out_oe_o(oe),
      .output_data_clock_o(dclk), .drive_current_o(cur),
      .term_en_o(term), .lvds_en_o(lvds), .ddr_en_o(ddr));

   aofc_cap_model u_cap (.sys_clk_i(sys_clk), .rstn_i(rstn),
      .data_clk_i(dclk), .word_i(out_word), .cap_word_o(cap),
      .cap_cnt_o(cap_cnt));

   task automatic chk(input logic [16:0] got, input logic [16:0] exp,
         input string msg);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic clks(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   // half periods of 8 clocks leave room for the pin synchronisers
   task automatic spi(input logic [15:0] wd, output logic [7:0] rd);
      cs_n = 0;
      clks(8);
      for (int i = 0; i < 16; i++) begin
         sdi = wd[15-i];
         clks(8);
         // open drain with pull-up: enable low reads as one
         if (i >= 8) rd[15-i] = !sdo_oe;
         sck = 1;
         clks(8);
         sck = 0;
      end
      clks(8);
      cs_n = 1;
      sdi = 0;
      clks(10);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] dat);
      logic [7:0] r;
      spi({1'b0, a, dat}, r);
   endtask

   // data bits carry junk so an ignored read-back payload is exercised
   task automatic rd(input logic [6:0] a, output logic [7:0] dat);
      spi({1'b1, a, 8'h5a}, dat);
   endtask

   task automatic get_word(output aofc_sample_t w);
      int c;
      c = cap_cnt;
      for (int k = 0; k < 100 && cap_cnt == c; k++) @(negedge sys_clk);
      if (cap_cnt == c) begin
         err_count++;
         $display("CHECK FAILED %0t no output word", $time);
      end
      w = cap;
   endtask

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #500000;
      err_count++;
      stop_test();
   end

   initial begin
      clks(5);
      rstn = 1;
      clks(5);
      rd(ADDR_DRIVE, d);
      chk(17'(d), 17'h0, "drive reg reset");
      rd(ADDR_FMT, d);
      chk(17'(d), 17'h0, "fmt reg reset");
      chk(17'(cur), 17'h0_015e, "reset current");
      chk(17'(oe), 17'h1, "reset oe");
      chk(17'(sdo), 17'h0, "sdo only pulls low");
      end_test("reset");
      // far side stalled: link clock held still while the buffer fills
      n = 0;
      repeat (12) begin
         @(negedge sys_clk);
         if (ready) begin
            smp = {1'b0, 16'h0100 + 16'(n)};
            valid = 1;
            n++;
         end else valid = 0;
      end
      valid = 0;
      chk(17'(n), 17'(FIFO_DEPTH), "accepted count");
      chk(17'(ready), 17'h0, "full refuses");
      link_run = 1;
      for (int k = 0; k < 9; k++) begin
         get_word(w1);
         chk(w1, {1'b0, 16'h0100 + 16'(k < 8 ? k : 7)}, "drain order");
      end
      end_test("fifo");
      smp = 17'h0_1235;
      valid = 1;
      for (int p = 0; p < 6; p++) begin
         wr(ADDR_FMT, pf[p]);
         repeat (3) get_word(w1);
         chk(w1, pe[p], "format or pattern");
      end
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_FMT, p ? 8'h38 : 8'h28);
         repeat (3) get_word(w1);
         get_word(w2);
         chk(w1 ^ w2, 17'h1_ffff, "pattern alternates");
         chk(17'(p ? (w1 == 17'h0 || w1 == 17'h1_ffff)
            : (w1 == CHK_A || w1 == CHK_B)), 17'h1, "pattern value");
      end
      end_test("patterns");
      for (int c = 0; c < 16; c++) begin
         v = {1'b1, 3'(c >> 1), 1'(c), 1'b0, 2'(c >> 1)};
         wr(ADDR_DRIVE, v);
         chk(17'(cur), 17'(cur_tab[c>>1]) << c[0], "current");
         chk(17'(term), 17'(c[0]), "termination");
         chk(17'(lvds), 17'(v[1:0] == 2'h1), "lvds mode");
         chk(17'(ddr), 17'(v[1:0] == 2'h1 || v[1:0] == 2'h2), "ddr");
         rd(ADDR_DRIVE, d);
         chk(17'(d), 17'(v & 8'h7f), "drive readback");
      end
      // ddr: the capture on the falling clock sees the even-bit half
      wr(ADDR_FMT, 8'h00);
      wr(ADDR_DRIVE, 8'h01);
      repeat (3) get_word(w1);
      chk(w1, 17'h0_0047, "ddr even half");
      // nap the converter before its outputs are switched off
      wr(7'h01, 8'h02);
      wr(ADDR_DRIVE, 8'h04);
      chk(17'(oe), 17'h0, "outputs off");
      wr(ADDR_DRIVE, 8'h00);
      chk(17'(oe), 17'h1, "outputs on");
      wr(7'h01, 8'h00);
      wr(ADDR_FMT, 8'hc7);
      rd(ADDR_FMT, d);
      chk(17'(d), 17'h0007, "fmt readback");
      rd(ADDR_FMT, d);
      chk(17'(d), 17'h0007, "read keeps reg");
      rd(7'h05, d);
      chk(17'(d), 17'h0, "unmapped read");
      wr(ADDR_DRIVE, 8'h35);
      wr(ADDR_RESET, 8'h80);
      rd(ADDR_DRIVE, d);
      chk(17'(d), 17'h0, "soft reset drive");
      rd(ADDR_FMT, d);
      chk(17'(d), 17'h0, "soft reset fmt");
      chk(17'(cur), 17'h0_015e, "soft reset current");
      end_test("registers");
      stop_test();
   end
endmodule
